// [arr_calc_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface arr_calc_if;
	logic [23:0] addr;
	logic [11:0] offset;
	logic        en;
	logic [23:0] result;

	modport calc (input addr, input offset, input en, output result);
	modport user (output addr, output offset, output en, input result);
endinterface : arr_calc_if

`default_nettype wire

// [arr_defines.svh]
`ifndef ARR_DEFINES_SVH
`define ARR_DEFINES_SVH

// ----------------------------------------
// relocation word layout (bit 31 = leading bit 0)
// ----------------------------------------
`define ARR_TOP_HI      31
`define ARR_TOP_LO      29
`define ARR_FLAGS_HI    28
`define ARR_FLAGS_LO    24
`define ARR_OFF_HI      23
`define ARR_OFF_LO      12
`define ARR_LOW_HI      11
`define ARR_LOW_LO      0

// ----------------------------------------
// storage placement and strobes
// ----------------------------------------
`define ARR_REG_WBASE   22'h000050
`define ARR_BE_READ     4'h0
`define ARR_BE_FLAGS    4'h8

// ----------------------------------------
// reset and fixed values
// ----------------------------------------
`define ARR_FLAGS_RST   5'h00
`define ARR_OFF_RST     12'h000
`define ARR_KEY_RST     4'h0
`define ARR_LBR_FLAGS   5'h15

`endif

// [arr_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

module arr_mem_model (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	// storage port
	input  wire logic        mem_req_i,
	input  wire logic [3:0]  mem_be_i,
	input  wire logic [21:0] mem_addr_i,
	input  wire logic [31:0] mem_wdata_i,
	input  wire logic [1:0]  delay_i,
	output var logic [31:0]  mem_rdata_o,
	output var logic         mem_ack_o,
	output var logic         bad_o
);
	// ----------------------------------------
	// sixteen register words in low storage
	// ----------------------------------------
	logic [31:0] words [16];
	logic [1:0]  cnt_q;
	wire logic   addr_ok = (mem_addr_i[21:4] == 18'h00005);

	// ----------------------------------------
	// slow or prompt answer, lane write
	// ----------------------------------------
	always @(posedge ref_clk_i) begin
		mem_ack_o   <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o; // stale data never looks valid
		if (!resetn_i) begin
			cnt_q <= 2'h0;
			bad_o <= 1'b0;
		end else if (mem_req_i && !mem_ack_o) begin
			if (cnt_q == delay_i) begin
				cnt_q       <= 2'h0;
				mem_ack_o   <= 1'b1;
				mem_rdata_o <= words[mem_addr_i[3:0]];
				if (!addr_ok)
					bad_o <= 1'b1;
				if (mem_be_i == 4'h8)
					words[mem_addr_i[3:0]][31:24] <= mem_wdata_i[31:24];
				else if (mem_be_i != 4'h0)
					bad_o <= 1'b1; // low bits must never be written
			end else begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule : arr_mem_model

`default_nettype wire

// [arr_pkg.sv]
`default_nettype none

package arr_pkg;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ARR_OP_LOAD                = 2'h0,
		ARR_OP_BRANCH_LINK_EXT     = 2'h1,
		ARR_OP_BRANCH_RETURN_EXT   = 2'h2,
		ARR_OP_LOAD_BASE_RELATIVIZE = 2'h3
	} arr_op_t;

	typedef enum logic [2:0] {
		ARR_K_INSTR  = 3'h0,
		ARR_K_DEST   = 3'h1,
		ARR_K_ORIGIN = 3'h2,
		ARR_K_INDIR  = 3'h3,
		ARR_K_IO     = 3'h4
	} arr_kind_t;

	typedef enum logic [1:0] {
		ARR_ST_IDLE = 2'h0,
		ARR_ST_LOAD = 2'h1,
		ARR_ST_IO   = 2'h3,
		ARR_ST_WB   = 2'h2
	} arr_state_t;

	typedef struct packed {
		logic relative_instr_flag;
		logic indirect_dest_flag;
		logic relative_dest_flag;
		logic indirect_origin_flag;
		logic relative_origin_flag;
	} arr_flags_t;

endpackage : arr_pkg

`default_nettype wire

// [arr_reloc_calc.sv]
`timescale 1ns/1ps
`default_nettype none

module arr_reloc_calc (
	// ----------------------------------------
	// operands and result
	// ----------------------------------------
	arr_calc_if.calc c
);

	// ----------------------------------------
	// high field gets the offset, rest passes
	// ----------------------------------------
	wire [11:0] sum_hi = c.addr[23:12] + c.offset;
	// carry out of the field is dropped so storage wraps
	assign c.result = c.en ? {sum_hi, c.addr[11:0]} : c.addr;

endmodule : arr_reloc_calc

`default_nettype wire

// [arr_reloc_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "arr_defines.svh"

module arr_reloc_unit (
	// clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 resetn_i,
	input  wire logic                 clear_i,
	// flag and load commands
	input  wire logic                 cmd_valid_i,
	input  wire arr_pkg::arr_op_t     cmd_op_i,
	input  wire logic [3:0]           cmd_key_i,
	input  wire arr_pkg::arr_flags_t  cmd_flags_i,
	input  wire logic                 cmd_r_i,
	// translation requests
	input  wire logic                 xlat_valid_i,
	input  wire arr_pkg::arr_kind_t   xlat_kind_i,
	input  wire logic [23:0]          xlat_addr_i,
	input  wire logic                 xlat_r_i,
	input  wire logic [3:0]           io_key_i,
	// status and results
	output var logic                  ready_o,
	output var logic                  cmd_done_o,
	output var logic                  spec_exc_o,
	output var logic                  xlat_done_o,
	output var logic [23:0]           xlat_addr_o,
	output var logic                  xlat_reloc_o,
	output var logic                  xlat_indirect_o,
	output var logic [31:0]           cur_reg_o,
	output var logic [3:0]            cur_key_o,
	// main storage
	output var logic                  mem_req_o,
	output var logic [3:0]            mem_be_o,
	output var logic [21:0]           mem_addr_o,
	output var logic [31:0]           mem_wdata_o,
	input  wire logic [31:0]          mem_rdata_i,
	input  wire logic                 mem_ack_i
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [21:0] reg_word(input logic [3:0] key);
		reg_word = `ARR_REG_WBASE + {18'h00000, key};
	endfunction : reg_word

	function automatic logic kind_reloc(input arr_pkg::arr_kind_t k,
		input arr_pkg::arr_flags_t f, input logic r);
		case (k)
			arr_pkg::ARR_K_INSTR:  kind_reloc = f.relative_instr_flag;
			arr_pkg::ARR_K_DEST:   kind_reloc = f.relative_dest_flag;
			arr_pkg::ARR_K_ORIGIN: kind_reloc = f.relative_origin_flag;
			arr_pkg::ARR_K_INDIR:  kind_reloc = r;
			default:               kind_reloc = 1'b1;
		endcase
	endfunction : kind_reloc

	// ----------------------------------------
	// state
	// ----------------------------------------
	arr_pkg::arr_state_t  state_q, state_d;
	arr_pkg::arr_flags_t  flags_q;
	logic [11:0]          off_q;
	logic [3:0]           key_q;
	logic [23:0]          src_q;
	logic [11:0]          off_used_q;
	logic                 ready_q, cmd_done_q, spec_q, done_q, reloc_q, indir_q;
	logic [23:0]          xaddr_q;
	logic                 req_q;
	logic [3:0]           be_q;
	logic [21:0]          maddr_q;
	logic [31:0]          wdata_q;

	arr_calc_if calc ();

	arr_reloc_calc u_calc (
		.c (calc)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// commands win over translations when both arrive together
	wire cmd_take  = cmd_valid_i & ready_q;
	wire xlat_take = xlat_valid_i & ready_q & ~cmd_valid_i;
	wire ack       = req_q & mem_ack_i;
	wire in_io     = (state_q == arr_pkg::ARR_ST_IO);
	wire is_io     = (xlat_kind_i == arr_pkg::ARR_K_IO);

	arr_pkg::arr_flags_t link_flags;
	always_comb begin
		link_flags = flags_q;
		link_flags.relative_instr_flag = cmd_r_i;
	end

	wire arr_pkg::arr_flags_t new_flags =
		(cmd_op_i == arr_pkg::ARR_OP_BRANCH_LINK_EXT) ? link_flags :
		(cmd_op_i == arr_pkg::ARR_OP_LOAD_BASE_RELATIVIZE) ?
			arr_pkg::arr_flags_t'(`ARR_LBR_FLAGS) : cmd_flags_i;

	// return with all relative flags cleared while instruction flag set
	wire bad_ret = (cmd_op_i == arr_pkg::ARR_OP_BRANCH_RETURN_EXT) &
		flags_q.relative_instr_flag & ~(cmd_flags_i.relative_instr_flag |
		cmd_flags_i.relative_dest_flag | cmd_flags_i.relative_origin_flag);

	wire is_load   = (cmd_op_i == arr_pkg::ARR_OP_LOAD);
	wire upd_flags = cmd_take & ~is_load & ~bad_ret;

	// channel path takes offset straight from the keyed storage word
	assign calc.addr   = in_io ? src_q : xlat_addr_i;
	assign calc.offset = in_io ? mem_rdata_i[`ARR_OFF_HI:`ARR_OFF_LO] : off_q;
	assign calc.en     = in_io ? 1'b1 : kind_reloc(xlat_kind_i, flags_q, xlat_r_i);

	// relative flag evaluated first; indirect flag only tags the result
	wire indir_d = (xlat_kind_i == arr_pkg::ARR_K_DEST)   ? flags_q.indirect_dest_flag :
	               (xlat_kind_i == arr_pkg::ARR_K_ORIGIN) ? flags_q.indirect_origin_flag :
	               1'b0;

	wire done_d = (xlat_take & ~is_io) | (in_io & ack);

	always_comb begin
		state_d = state_q;
		case (state_q)
			arr_pkg::ARR_ST_IDLE: begin
				if (cmd_take & is_load)
					state_d = arr_pkg::ARR_ST_LOAD;
				else if (upd_flags)
					state_d = arr_pkg::ARR_ST_WB;
				else if (xlat_take & is_io)
					state_d = arr_pkg::ARR_ST_IO;
			end
			arr_pkg::ARR_ST_LOAD,
			arr_pkg::ARR_ST_IO,
			arr_pkg::ARR_ST_WB: begin
				if (ack)
					state_d = arr_pkg::ARR_ST_IDLE;
			end
			default: state_d = arr_pkg::ARR_ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// control flops
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i || clear_i) begin
			state_q <= arr_pkg::ARR_ST_IDLE;
			ready_q <= 1'b1;
		end else begin
			state_q <= state_d;
			ready_q <= (state_d == arr_pkg::ARR_ST_IDLE);
		end
	end

	// ----------------------------------------
	// current relocation register
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i || clear_i) begin
			flags_q <= `ARR_FLAGS_RST;
			off_q   <= `ARR_OFF_RST;
			key_q   <= `ARR_KEY_RST;
		end else if (cmd_take & is_load) begin
			key_q <= cmd_key_i;
		end else if (upd_flags) begin
			flags_q <= new_flags;
		end else if ((state_q == arr_pkg::ARR_ST_LOAD) & ack) begin
			// storage leading and low bits are never captured
			flags_q <= mem_rdata_i[`ARR_FLAGS_HI:`ARR_FLAGS_LO];
			off_q   <= mem_rdata_i[`ARR_OFF_HI:`ARR_OFF_LO];
		end
	end

	// ----------------------------------------
	// storage port
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i || clear_i) begin
			req_q   <= 1'b0;
			be_q    <= `ARR_BE_READ;
			maddr_q <= 22'h000000;
			wdata_q <= 32'h00000000;
		end else if (cmd_take & is_load) begin
			req_q   <= 1'b1;
			be_q    <= `ARR_BE_READ;
			maddr_q <= reg_word(cmd_key_i);
		end else if (upd_flags) begin
			// only the flags byte lane is written; offset and low bits stay
			req_q   <= 1'b1;
			be_q    <= `ARR_BE_FLAGS;
			maddr_q <= reg_word(key_q);
			wdata_q <= {3'h0, new_flags, 24'h000000};
		end else if (xlat_take & is_io) begin
			req_q   <= 1'b1;
			be_q    <= `ARR_BE_READ;
			maddr_q <= reg_word(io_key_i);
		end else if (ack) begin
			req_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// result flops
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i || clear_i) begin
			done_q     <= 1'b0;
			cmd_done_q <= 1'b0;
			spec_q     <= 1'b0;
		end else begin
			done_q     <= done_d;
			spec_q     <= cmd_take & bad_ret;
			cmd_done_q <= (cmd_take & bad_ret) |
				(ack & (state_q != arr_pkg::ARR_ST_IO));
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			xaddr_q    <= 24'h000000;
			reloc_q    <= 1'b0;
			indir_q    <= 1'b0;
			src_q      <= 24'h000000;
			off_used_q <= 12'h000;
		end else begin
			if (xlat_take)
				src_q <= xlat_addr_i;
			if (done_d) begin
				xaddr_q    <= calc.result;
				reloc_q    <= calc.en;
				indir_q    <= in_io ? 1'b0 : indir_d;
				off_used_q <= calc.offset;
			end
		end
	end

	assign ready_o         = ready_q;
	assign cmd_done_o      = cmd_done_q;
	assign spec_exc_o      = spec_q;
	assign xlat_done_o     = done_q;
	assign xlat_addr_o     = xaddr_q;
	assign xlat_reloc_o    = reloc_q;
	assign xlat_indirect_o = indir_q;
	assign cur_reg_o       = {3'h0, flags_q, off_q, 12'h000};
	assign cur_key_o       = key_q;
	assign mem_req_o       = req_q;
	assign mem_be_o        = be_q;
	assign mem_addr_o      = maddr_q;
	assign mem_wdata_o     = wdata_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i || clear_i);
	property p_wb_zero;
		mem_req_o && (mem_be_o == `ARR_BE_FLAGS) |->
			mem_wdata_o[31:24] == {3'h0, cur_reg_o[28:24]};
	endproperty
	a_wb_zero: assert property (p_wb_zero) else $error("write-back word wrong");
	property p_cur_bits;
		(state_q == arr_pkg::ARR_ST_LOAD) && ack |=>
			cur_reg_o == {3'h0, $past(mem_rdata_i[28:12]), 12'h000};
	endproperty
	a_cur_bits: assert property (p_cur_bits) else $error("load capture wrong");
	property p_io_reloc;
		xlat_take && is_io |-> ##[2:1000] xlat_done_o && xlat_reloc_o;
	endproperty
	a_io_reloc: assert property (p_io_reloc) else $error("channel ref not relocated");
	property p_instr;
		xlat_take && xlat_kind_i == arr_pkg::ARR_K_INSTR |=>
			xlat_done_o && xlat_reloc_o == $past(flags_q.relative_instr_flag);
	endproperty
	a_instr: assert property (p_instr) else $error("instruction relocation wrong");
	property p_dest;
		xlat_take && xlat_kind_i == arr_pkg::ARR_K_DEST |=>
			xlat_indirect_o == $past(flags_q.indirect_dest_flag) &&
			xlat_reloc_o == $past(flags_q.relative_dest_flag);
	endproperty
	a_dest: assert property (p_dest) else $error("destination handling wrong");
	property p_origin;
		xlat_take && xlat_kind_i == arr_pkg::ARR_K_ORIGIN |=>
			xlat_indirect_o == $past(flags_q.indirect_origin_flag) &&
			xlat_reloc_o == $past(flags_q.relative_origin_flag);
	endproperty
	a_origin: assert property (p_origin) else $error("origin handling wrong");
	property p_sum;
		xlat_done_o && xlat_reloc_o |->
			xlat_addr_o[23:12] == src_q[23:12] + off_used_q && xlat_addr_o[11:0] == src_q[11:0];
	endproperty
	a_sum: assert property (p_sum) else $error("relocated address wrong");
	property p_zero_off;
		xlat_done_o && (off_used_q == 12'h000 || !xlat_reloc_o) |-> xlat_addr_o == src_q;
	endproperty
	a_zero_off: assert property (p_zero_off) else $error("address changed w/o offset");
	property p_indir;
		xlat_take && xlat_kind_i == arr_pkg::ARR_K_INDIR |=> xlat_reloc_o == $past(xlat_r_i);
	endproperty
	a_indir: assert property (p_indir) else $error("indirect word relocation wrong");
	property p_keyed;
		mem_req_o |-> mem_addr_o >= `ARR_REG_WBASE && mem_addr_o <= `ARR_REG_WBASE + 22'h00000F;
	endproperty
	a_keyed: assert property (p_keyed) else $error("register address out of range");
	property p_clear;
		resetn_i && clear_i |=> cur_reg_o == 32'h00000000;
	endproperty
	a_clear: assert property (disable iff (!resetn_i) p_clear) else $error("clear failed");
	property p_lbr;
		cmd_take && cmd_op_i == arr_pkg::ARR_OP_LOAD_BASE_RELATIVIZE |=>
			flags_q == arr_pkg::arr_flags_t'(`ARR_LBR_FLAGS);
	endproperty
	a_lbr: assert property (p_lbr) else $error("fixed flag pattern wrong");
	c_io: cover property (xlat_take && is_io ##[2:20] xlat_done_o);
	c_load: cover property (cmd_take && is_load ##[2:20] cmd_done_o);
	c_exc: cover property (spec_exc_o);
	c_wb: cover property (mem_req_o && mem_ack_i && mem_be_o == `ARR_BE_FLAGS);

endmodule : arr_reloc_unit

`default_nettype wire

// [test_address_relocation_register.sv]
`timescale 1ns/1ps
`default_nettype none

module test_address_relocation_register;
	logic                ref_clk_i, resetn_i, clear_i, cmd_valid_i, cmd_r_i;
	logic                xlat_valid_i, xlat_r_i, ready_o, cmd_done_o, spec_exc_o;
	logic                xlat_done_o, xlat_reloc_o, xlat_indirect_o, mem_req_o, mem_ack_i, mbad;
	arr_pkg::arr_op_t    cmd_op_i;
	arr_pkg::arr_flags_t cmd_flags_i, ef;
	arr_pkg::arr_kind_t  xlat_kind_i;
	logic [3:0]          cmd_key_i, io_key_i, cur_key_o, mem_be_o, ek;
	logic [23:0]         xlat_addr_i, xlat_addr_o;
	logic [31:0]         cur_reg_o, mem_wdata_o, mem_rdata_i, rv;
	logic [21:0]         mem_addr_o;
	logic [11:0]         eo;
	logic [1:0]          mdly;
	integer              seed, bad_count, cmp_count, n, k;

	arr_reloc_unit dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clear_i(clear_i),
		.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_key_i(cmd_key_i),
		.cmd_flags_i(cmd_flags_i), .cmd_r_i(cmd_r_i), .xlat_valid_i(xlat_valid_i),
		.xlat_kind_i(xlat_kind_i), .xlat_addr_i(xlat_addr_i), .xlat_r_i(xlat_r_i),
		.io_key_i(io_key_i), .ready_o(ready_o), .cmd_done_o(cmd_done_o),
		.spec_exc_o(spec_exc_o), .xlat_done_o(xlat_done_o), .xlat_addr_o(xlat_addr_o),
		.xlat_reloc_o(xlat_reloc_o), .xlat_indirect_o(xlat_indirect_o),
		.cur_reg_o(cur_reg_o), .cur_key_o(cur_key_o), .mem_req_o(mem_req_o),
		.mem_be_o(mem_be_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));

	arr_mem_model mem_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mem_req_i(mem_req_o),
		.mem_be_i(mem_be_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
		.delay_i(mdly), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i), .bad_o(mbad));

	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [23:0] reloc_addr(input logic [23:0] a, input logic [11:0] o,
		input logic rel);
		return rel ? {a[23:12] + o, a[11:0]} : a;
	endfunction : reloc_addr

	task conclude;
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task check(input logic ok, input string msg);
		cmp_count++;
		if (!ok) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check

	task wait_for(input bit cmd);
		int i;
		for (i = 0; i < 40; i++) begin
			#1;
			if ((cmd ? cmd_done_o : xlat_done_o) === 1'b1)
				break;
			@(posedge ref_clk_i);
		end
		if (i == 40) begin
			check(1'b0, "timeout");
			conclude();
		end
	endtask : wait_for

	task do_cmd(input arr_pkg::arr_op_t op, input logic [3:0] key,
		input arr_pkg::arr_flags_t f, input logic r);
		logic                exc;
		arr_pkg::arr_flags_t nf;
		logic [31:0]         old;
		nf  = ef;
		exc = 1'b0;
		case (op)
			arr_pkg::ARR_OP_BRANCH_LINK_EXT: nf.relative_instr_flag = r;
			arr_pkg::ARR_OP_BRANCH_RETURN_EXT: begin
				nf  = f;
				exc = ef.relative_instr_flag & ~f.relative_instr_flag &
					~f.relative_dest_flag & ~f.relative_origin_flag;
			end
			arr_pkg::ARR_OP_LOAD_BASE_RELATIVIZE: nf = 5'h15; // ri rd ro set
			default: ;
		endcase
		old = mem_u.words[(op == arr_pkg::ARR_OP_LOAD) ? key : ek];
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_op_i    <= op;
		cmd_key_i   <= key;
		cmd_flags_i <= f;
		cmd_r_i     <= r;
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b0;
		wait_for(1'b1);
		check(spec_exc_o === exc, "exception pulse");
		if (op == arr_pkg::ARR_OP_LOAD) begin
			ef = old[28:24];
			eo = old[23:12];
			ek = key;
		end else if (!exc) begin
			ef = nf;
			check(mem_u.words[ek] === {3'h0, nf, old[23:0]}, "stored word");
		end else begin
			check(mem_u.words[ek] === old, "stored word after exception");
		end
		@(posedge ref_clk_i);
		#1;
		check(cur_reg_o === {3'h0, ef, eo, 12'h000}, "current register");
		check(cur_key_o === ek, "current key");
	endtask : do_cmd

	task do_xlat(input arr_pkg::arr_kind_t kind, input logic [23:0] a, input logic r,
		input logic [3:0] iok);
		logic       rel, ind;
		logic [11:0] off;
		off = (kind == arr_pkg::ARR_K_IO) ? mem_u.words[iok][23:12] : eo;
		ind = 1'b0;
		case (kind)
			arr_pkg::ARR_K_INSTR: rel = ef.relative_instr_flag;
			arr_pkg::ARR_K_DEST: begin
				rel = ef.relative_dest_flag;
				ind = ef.indirect_dest_flag;
			end
			arr_pkg::ARR_K_ORIGIN: begin
				rel = ef.relative_origin_flag;
				ind = ef.indirect_origin_flag;
			end
			arr_pkg::ARR_K_INDIR: rel = r;
			default: rel = 1'b1;
		endcase
		@(posedge ref_clk_i);
		xlat_valid_i <= 1'b1;
		xlat_kind_i  <= kind;
		xlat_addr_i  <= a;
		xlat_r_i     <= r;
		io_key_i     <= iok;
		@(posedge ref_clk_i);
		xlat_valid_i <= 1'b0;
		wait_for(1'b0);
		check(xlat_addr_o === reloc_addr(a, off, rel), "address");
		check(xlat_reloc_o === rel, "relocate");
		check(xlat_indirect_o === ind, "indirect");
	endtask : do_xlat

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{resetn_i, clear_i, cmd_valid_i, cmd_r_i, xlat_valid_i, xlat_r_i} = 6'h00;
		cmd_op_i    = arr_pkg::ARR_OP_LOAD;
		xlat_kind_i = arr_pkg::ARR_K_INSTR;
		{cmd_key_i, io_key_i, cmd_flags_i, xlat_addr_i, mdly} = 39'h0;
		{bad_count, cmp_count, ef, eo, ek} = '0;
		seed = 32'hCD3C;
		for (k = 0; k < 16; k++)
			mem_u.words[k] = $random(seed);
		mem_u.words[3][23:12] = 12'h000; // zero offset corner
		mem_u.words[5] = 32'hFFFFFFFF; // leading and low bits all set
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		#1;
		check(cur_reg_o === 32'h00000000 && ready_o === 1'b1, "after reset");
		$display("test reset done");
		do_cmd(arr_pkg::ARR_OP_LOAD, 4'h5, 5'h00, 1'b0);
		do_cmd(arr_pkg::ARR_OP_LOAD_BASE_RELATIVIZE, 4'h0, 5'h00, 1'b0);
		do_cmd(arr_pkg::ARR_OP_BRANCH_RETURN_EXT, 4'h0, 5'h0A, 1'b0);
		$display("test exception done");
		for (n = 0; n < 40; n++) begin
			rv   = $random(seed);
			mdly = rv[11:10];
			do_cmd(arr_pkg::ARR_OP_LOAD, (n % 8 == 0) ? 4'h3 : rv[15:12], 5'h00, 1'b0);
			do_cmd(arr_pkg::arr_op_t'(rv[1:0]), 4'h0, rv[8:4], rv[9]);
			for (k = 0; k < 5; k++) begin
				rv = $random(seed);
				do_xlat(arr_pkg::arr_kind_t'(k), rv[23:0], rv[24], rv[31:28]);
			end
		end
		$display("test random done");
		@(posedge ref_clk_i);
		clear_i <= 1'b1;
		@(posedge ref_clk_i);
		clear_i <= 1'b0;
		#1;
		check(cur_reg_o === 32'h00000000 && cur_key_o === 4'h0, "cleared state");
		{ef, eo, ek} = '0;
		do_xlat(arr_pkg::ARR_K_INSTR, 24'hABC123, 1'b1, 4'h0);
		check(mbad === 1'b0, "storage address or lanes");
		$display("test clear done");
		conclude();
	end
endmodule : test_address_relocation_register

`default_nettype wire
